// ### rtl/cc_timer_pkg.sv
package cc_timer_pkg;

    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [5:0] port_d_data_idx = 6'h03;
    localparam logic [5:0] timer_control_idx = 6'h12;
    localparam logic [5:0] timer_flags_idx = 6'h13;
    localparam logic [5:0] capture_high_idx = 6'h14;
    localparam logic [5:0] capture_low_idx = 6'h15;
    localparam logic [5:0] compare_high_idx = 6'h16;
    localparam logic [5:0] compare_low_idx = 6'h17;
    localparam logic [5:0] counter_high_idx = 6'h18;
    localparam logic [5:0] counter_low_idx = 6'h19;
    localparam logic [5:0] alt_counter_high_idx = 6'h1a;
    localparam logic [5:0] alt_counter_low_idx = 6'h1b;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int capture_irq_enable_bit = 7;
    localparam int compare_irq_enable_bit = 6;
    localparam int overflow_irq_enable_bit = 5;
    localparam int capture_edge_select_bit = 1;
    localparam int compare_output_level_bit = 0;
    localparam int capture_flag_bit = 7;
    localparam int compare_flag_bit = 6;
    localparam int overflow_flag_bit = 5;
    localparam int port_d_bit_seven_pos = 7;

    // ********************************************************
    // reset values and counts
    // ********************************************************
    localparam logic [15:0] counter_reset = 16'hfffc;
    localparam logic [15:0] counter_all_ones = 16'hffff;
    localparam logic [1:0] prescale_last = 2'h3;
    localparam logic compare_pin_reset = 1'b0;

    // ********************************************************
    // bus answers
    // ********************************************************
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// ### rtl/prescale_div4.sv
`timescale 1ns/1ps
`default_nettype none

module prescale_div4 (
    input wire logic core_clk,
    input wire logic srst,
    output logic tick
);

    logic [1:0] phase;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign tick = (phase == cc_timer_pkg::prescale_last);

endmodule

`default_nettype wire

// ### rtl/pin_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic pin_async,
    input wire logic rising_select,
    output logic pin_level,
    output logic edge_pulse
);

    logic stage1;
    logic stage2;
    logic prev;

    // stage1 feeds only stage2, so metastability never reaches the edge logic
    // no reset: the chain follows the pin through reset, so an idle-high pin
    // cannot fake a rising edge just after release
    always_ff @(posedge core_clk) begin
        stage1 <= pin_async;
        stage2 <= stage1;
        prev <= stage2;
    end

    assign pin_level = stage2;
    assign edge_pulse = ~srst & (rising_select ? (stage2 & ~prev) : (~stage2 & prev));

endmodule

`default_nettype wire

// ### rtl/capture_compare_timer.sv
// Overview of operation
// - counter advances every fourth clock, wraps
// - counter reads never disturb the counting
// - selected capture edge copies counter
// - capture pin readable as port bit
// - edge select: 1 rising, 0 falling; kept
// - every fourth clock compare drives pin
// - output level bit sets pin; reset clears
// - capture interrupt enable, cleared by reset
// - compare interrupt enable, cleared by reset
// - overflow interrupt enable, cleared by reset
// - capture flag: status read, capture low read
// - compare flag: status read, compare low access
// - overflow flag: status read, counter low access
// - high byte read freezes low byte
// - counter writes are ignored
// - reset loads counter with fffc
// - capture high read blocks captures
// - compare high write blocks compares
// - alternate counter path leaves overflow alone
`timescale 1ns/1ps
`default_nettype none

module capture_compare_timer (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_pin,
    output logic compare_pin,
    output logic timer_irq
);

    // ********************************************************
    // state
    // ********************************************************
    logic tick;
    logic capture_level;
    logic capture_edge;
    logic [15:0] counter;
    logic [15:0] capture;
    logic [15:0] compare;
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    // no reset on these four: they keep their value across a reset
    logic capture_edge_select = 1'b0;
    logic capture_flag = 1'b0;
    logic compare_flag = 1'b0;
    logic overflow_flag = 1'b0;
    logic compare_output_level;
    logic capture_armed;
    logic compare_armed;
    logic overflow_armed;
    logic capture_inhibit;
    logic compare_inhibit;
    logic cnt_latched;
    logic [7:0] cnt_buf;
    logic alt_latched;
    logic [7:0] alt_buf;
    logic aw_got;
    logic w_got;
    logic [5:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane;

    // ********************************************************
    // prescaler and capture pin
    // ********************************************************
    prescale_div4 u_prescale (
        .core_clk(core_clk),
        .srst(srst),
        .tick(tick)
    );

    pin_edge_sync u_capture_sync (
        .core_clk(core_clk),
        .srst(srst),
        .pin_async(capture_pin),
        .rising_select(capture_edge_select),
        .pin_level(capture_level),
        .edge_pulse(capture_edge)
    );

    // ********************************************************
    // bus strobes
    // ********************************************************
    logic rd_take;
    logic [5:0] rd_idx;
    logic wr_do;
    logic rd_flags;
    logic rd_cap_high;
    logic rd_cap_low;
    logic rd_cnt_high;
    logic rd_cnt_low;
    logic rd_alt_high;
    logic rd_alt_low;
    logic wr_cmp_high;
    logic wr_cmp_low;
    logic wr_cnt_low;
    logic match;

    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;
    assign rd_idx = s_axi_araddr[7:2];
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign wr_do = aw_got & w_got & ~s_axi_bvalid;

    assign rd_flags = rd_take & (rd_idx == cc_timer_pkg::timer_flags_idx);
    assign rd_cap_high = rd_take & (rd_idx == cc_timer_pkg::capture_high_idx);
    assign rd_cap_low = rd_take & (rd_idx == cc_timer_pkg::capture_low_idx);
    assign rd_cnt_high = rd_take & (rd_idx == cc_timer_pkg::counter_high_idx);
    assign rd_cnt_low = rd_take & (rd_idx == cc_timer_pkg::counter_low_idx);
    assign rd_alt_high = rd_take & (rd_idx == cc_timer_pkg::alt_counter_high_idx);
    assign rd_alt_low = rd_take & (rd_idx == cc_timer_pkg::alt_counter_low_idx);
    assign wr_cmp_high = wr_do & wr_lane & (wr_idx == cc_timer_pkg::compare_high_idx);
    assign wr_cmp_low = wr_do & wr_lane & (wr_idx == cc_timer_pkg::compare_low_idx);
    assign wr_cnt_low = wr_do & (wr_idx == cc_timer_pkg::counter_low_idx);
    assign match = tick & ~compare_inhibit & (counter == compare);

    // ********************************************************
    // counter, capture and compare
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            counter <= cc_timer_pkg::counter_reset;
        end else if (tick) begin
            counter <= counter + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (capture_edge && !capture_inhibit) begin
            capture <= counter;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            compare_pin <= cc_timer_pkg::compare_pin_reset;
        end else if (match) begin
            compare_pin <= compare_output_level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            capture_inhibit <= 1'b0;
            compare_inhibit <= 1'b0;
        end else begin
            if (rd_cap_high) begin
                capture_inhibit <= 1'b1;
            end else if (rd_cap_low) begin
                capture_inhibit <= 1'b0;
            end
            if (wr_cmp_high) begin
                compare_inhibit <= 1'b1;
            end else if (wr_cmp_low) begin
                compare_inhibit <= 1'b0;
            end
        end
    end

    // compare register has no reset, like the capture register
    always_ff @(posedge core_clk) begin
        if (wr_cmp_high) begin
            compare[15:8] <= wr_byte;
        end
        if (wr_cmp_low) begin
            compare[7:0] <= wr_byte;
        end
    end

    // ********************************************************
    // coherent counter reads
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_latched <= 1'b0;
            cnt_buf <= 8'h00;
            alt_latched <= 1'b0;
            alt_buf <= 8'h00;
        end else begin
            if (rd_cnt_high && !cnt_latched) begin
                cnt_latched <= 1'b1;
                cnt_buf <= counter[7:0];
            end else if (rd_cnt_low) begin
                cnt_latched <= 1'b0;
            end
            if (rd_alt_high && !alt_latched) begin
                alt_latched <= 1'b1;
                alt_buf <= counter[7:0];
            end else if (rd_alt_low) begin
                alt_latched <= 1'b0;
            end
        end
    end

    // ********************************************************
    // control register
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            capture_irq_enable <= 1'b0;
            compare_irq_enable <= 1'b0;
            overflow_irq_enable <= 1'b0;
            compare_output_level <= 1'b0;
        end else if (wr_do && wr_lane && wr_idx == cc_timer_pkg::timer_control_idx) begin
            capture_irq_enable <= wr_byte[cc_timer_pkg::capture_irq_enable_bit];
            compare_irq_enable <= wr_byte[cc_timer_pkg::compare_irq_enable_bit];
            overflow_irq_enable <= wr_byte[cc_timer_pkg::overflow_irq_enable_bit];
            compare_output_level <= wr_byte[cc_timer_pkg::compare_output_level_bit];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!srst && wr_do && wr_lane && wr_idx == cc_timer_pkg::timer_control_idx) begin
            capture_edge_select <= wr_byte[cc_timer_pkg::capture_edge_select_bit];
        end
    end

    // ********************************************************
    // status flags: a set in the clearing cycle wins
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (capture_edge && !capture_inhibit) begin
            capture_flag <= 1'b1;
        end else if (!srst && rd_cap_low && capture_armed) begin
            capture_flag <= 1'b0;
        end
        if (match) begin
            compare_flag <= 1'b1;
        end else if (!srst && (rd_take && rd_idx == cc_timer_pkg::compare_low_idx
                               || wr_do && wr_idx == cc_timer_pkg::compare_low_idx)
                     && compare_armed) begin
            compare_flag <= 1'b0;
        end
        if (tick && counter == cc_timer_pkg::counter_all_ones) begin
            overflow_flag <= 1'b1;
        end else if (!srst && (rd_cnt_low || wr_cnt_low) && overflow_armed) begin
            overflow_flag <= 1'b0;
        end
    end

    // arming remembers which flags the last status read saw set
    always_ff @(posedge core_clk) begin
        if (srst) begin
            capture_armed <= 1'b0;
            compare_armed <= 1'b0;
            overflow_armed <= 1'b0;
        end else begin
            if (rd_flags) begin
                capture_armed <= capture_flag;
            end else if (rd_cap_low) begin
                capture_armed <= 1'b0;
            end
            if (rd_flags) begin
                compare_armed <= compare_flag;
            end else if (rd_take && rd_idx == cc_timer_pkg::compare_low_idx
                         || wr_do && wr_idx == cc_timer_pkg::compare_low_idx) begin
                compare_armed <= 1'b0;
            end
            if (rd_flags) begin
                overflow_armed <= overflow_flag;
            end else if (rd_cnt_low || wr_cnt_low) begin
                overflow_armed <= 1'b0;
            end
        end
    end

    assign timer_irq = (capture_flag & capture_irq_enable)
                     | (compare_flag & compare_irq_enable)
                     | (overflow_flag & overflow_irq_enable);

    // ********************************************************
    // axi4-lite write channel
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_idx <= 6'h00;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cc_timer_pkg::resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_idx <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx == cc_timer_pkg::timer_control_idx
                                || wr_idx == cc_timer_pkg::compare_high_idx
                                || wr_idx == cc_timer_pkg::compare_low_idx
                                || (wr_idx >= cc_timer_pkg::port_d_data_idx
                                    && wr_idx == cc_timer_pkg::port_d_data_idx)
                                || (wr_idx >= cc_timer_pkg::timer_flags_idx
                                    && wr_idx <= cc_timer_pkg::alt_counter_low_idx))
                               ? cc_timer_pkg::resp_okay : cc_timer_pkg::resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************************************************
    // axi4-lite read channel
    // ********************************************************
    logic [7:0] rd_byte;
    logic rd_hit;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        if (rd_idx == cc_timer_pkg::port_d_data_idx) begin
            rd_byte[cc_timer_pkg::port_d_bit_seven_pos] = capture_level;
        end else if (rd_idx == cc_timer_pkg::timer_control_idx) begin
            rd_byte[cc_timer_pkg::capture_irq_enable_bit] = capture_irq_enable;
            rd_byte[cc_timer_pkg::compare_irq_enable_bit] = compare_irq_enable;
            rd_byte[cc_timer_pkg::overflow_irq_enable_bit] = overflow_irq_enable;
            rd_byte[cc_timer_pkg::capture_edge_select_bit] = capture_edge_select;
            rd_byte[cc_timer_pkg::compare_output_level_bit] = compare_output_level;
        end else if (rd_idx == cc_timer_pkg::timer_flags_idx) begin
            rd_byte[cc_timer_pkg::capture_flag_bit] = capture_flag;
            rd_byte[cc_timer_pkg::compare_flag_bit] = compare_flag;
            rd_byte[cc_timer_pkg::overflow_flag_bit] = overflow_flag;
        end else if (rd_idx == cc_timer_pkg::capture_high_idx) begin
            rd_byte = capture[15:8];
        end else if (rd_idx == cc_timer_pkg::capture_low_idx) begin
            rd_byte = capture[7:0];
        end else if (rd_idx == cc_timer_pkg::compare_high_idx) begin
            rd_byte = compare[15:8];
        end else if (rd_idx == cc_timer_pkg::compare_low_idx) begin
            rd_byte = compare[7:0];
        end else if (rd_idx == cc_timer_pkg::counter_high_idx
                     || rd_idx == cc_timer_pkg::alt_counter_high_idx) begin
            rd_byte = counter[15:8];
        end else if (rd_idx == cc_timer_pkg::counter_low_idx) begin
            rd_byte = cnt_latched ? cnt_buf : counter[7:0];
        end else if (rd_idx == cc_timer_pkg::alt_counter_low_idx) begin
            rd_byte = alt_latched ? alt_buf : counter[7:0];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= cc_timer_pkg::resp_okay;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? cc_timer_pkg::resp_okay : cc_timer_pkg::resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence three_idle_then_tick;
        !tick [*3] ##1 tick;
    endsequence

    presc_period_a: assert property (tick |=> three_idle_then_tick)
        else $error("prescaler tick not every fourth cycle");
    count_step_a: assert property (tick |=> counter == 16'($past(counter) + 16'h0001))
        else $error("counter did not advance on tick");
    count_hold_a: assert property (!tick |=> $stable(counter))
        else $error("counter moved without tick");
    capture_load_a: assert property (capture_edge && !capture_inhibit |=> capture == $past(counter))
        else $error("capture did not copy counter");
    capture_block_a: assert property (capture_inhibit |=> $stable(capture))
        else $error("capture changed while blocked");
    compare_drive_a: assert property (match |=> compare_pin == $past(compare_output_level))
        else $error("compare pin not driven with output level");
    compare_block_a: assert property (compare_inhibit |=> $stable(compare_pin))
        else $error("compare pin changed while blocked");
    overflow_set_a: assert property (tick && counter == 16'hffff |=> overflow_flag && counter == 16'h0000)
        else $error("overflow flag not set on wrap");
    latch_hold_a: assert property (cnt_latched && !rd_cnt_low |=> cnt_latched && $stable(cnt_buf))
        else $error("latched counter low byte lost");
    irq_map_a: assert property (timer_irq == ((capture_flag && capture_irq_enable)
                                || (compare_flag && compare_irq_enable)
                                || (overflow_flag && overflow_irq_enable)))
        else $error("interrupt request does not match flags");
    alt_keeps_a: assert property (rd_alt_low && !wr_cnt_low && !(tick && counter == 16'hffff)
                                  |=> overflow_flag == $past(overflow_flag))
        else $error("alternate read touched overflow flag");

endmodule

`default_nettype wire

// ### tb/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input wire logic core_clk,
    input wire logic compare_pin,
    output logic capture_pin
);
    initial capture_pin = 1'b0;
    int rises = 0;
    // the load counts each rise of the compare output
    always @(posedge compare_pin) rises <= rises + 1;
    // levels change just after an edge, so each one lasts at least a full cycle
    task automatic drive(input logic v);
        @(posedge core_clk);
        capture_pin <= v;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic awr, wrd, bv, arr, rv, cp, irq, cap;
    logic [7:0] awa = 8'h0, ara = 8'h0, d, h;
    logic [31:0] wd = 32'h0, rdat;
    logic [15:0] m = 16'hfffc, snap, cs, t;
    logic [1:0] ph = 2'h0, br, rr;
    logic [3:0] wst = 4'hf;
    int n_fail = 0, n_tests = 0, n;
    capture_compare_timer dut (
        .core_clk(core_clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .capture_pin(cap),
        .compare_pin(cp), .timer_irq(irq)
    );
    pin_source src (.core_clk(core_clk), .compare_pin(cp), .capture_pin(cap));
    always #2 core_clk = ~core_clk;
    // reference count: phase 0 after release, a step whenever the phase reaches 3
    always @(posedge core_clk) begin
        ph <= srst ? 2'h0 : ph + 2'h1;
        if (srst) m <= cc_timer_pkg::counter_reset;
        else if (ph == 2'h3) m <= m + 16'h1;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // sl allows that many ticks of slack, as the prescaler phase is hidden at the ports
    task automatic chk(input string s, input logic [15:0] e, g, input int sl = 0);
        n_tests++;
        if (g !== e && !(^g !== 1'bx && 16'(g - e + sl) <= 2 * sl)) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic step;
        @(posedge core_clk);
        if (++n > 400) begin
            n_fail++;
            end_sim;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        {awa, wd, awv, wv} <= {a, 2'h0, 24'h0, v, 2'h3};
        n = 0;
        do begin
            step;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        {ara, arv} <= {a, 2'h0, 1'b1};
        n = 0;
        do step; while (!arr);
        arv <= 1'b0;
        snap = m;
        do step; while (!rv);
        v = rdat[7:0];
    endtask
    task automatic rdk(input logic [7:0] k, e, input string s,
                       input logic [5:0] a = cc_timer_pkg::timer_flags_idx);
        rd(a, d);
        chk(s, {8'h0, e}, {8'h0, d & k});
    endtask
    task automatic capture(input logic [7:0] ctl, input logic lvl);
        wr(cc_timer_pkg::timer_control_idx, ctl);
        src.drive(lvl);
        repeat (3) @(posedge core_clk);
        cs = m;
        rdk(8'h80, 8'h80, "capture flag");
        rd(cc_timer_pkg::capture_high_idx, h);
    endtask
    initial begin
        void'($urandom(88));
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdk(8'hff, 8'h00, "control", cc_timer_pkg::timer_control_idx);
        chk("compare pin", 16'h0, {15'h0, cp});
        rdk(8'hff, 8'h00, "unmapped", 6'h3f);
        chk("rresp", {14'h0, cc_timer_pkg::resp_slverr}, {14'h0, rr});
        wr(6'h3f, 8'h00);
        chk("bresp", {14'h0, cc_timer_pkg::resp_slverr}, {14'h0, br});
        wst <= 4'h0;
        wr(cc_timer_pkg::timer_control_idx, 8'hff);
        wst <= 4'hf;
        chk("bresp", {14'h0, cc_timer_pkg::resp_okay}, {14'h0, br});
        rdk(8'hff, 8'h00, "control", cc_timer_pkg::timer_control_idx);
        $display("reset test done");
        repeat (20) @(posedge core_clk);
        wr(cc_timer_pkg::timer_control_idx, 8'h20);
        chk("irq", 16'h1, {15'h0, irq});
        rdk(8'ha0, 8'h20, "overflow flag");
        rd(cc_timer_pkg::alt_counter_high_idx, h);
        cs = snap;
        rd(cc_timer_pkg::alt_counter_low_idx, d);
        chk("alt counter", cs, {h, d}, 1);
        rdk(8'ha0, 8'h20, "overflow flag");
        wr(cc_timer_pkg::counter_low_idx, 8'h55);
        rdk(8'ha0, 8'h00, "overflow flag");
        chk("irq", 16'h0, {15'h0, irq});
        rd(cc_timer_pkg::counter_high_idx, h);
        cs = snap;
        repeat ($urandom_range(83, 20)) @(posedge core_clk);
        rd(cc_timer_pkg::counter_low_idx, d);
        chk("counter", cs, {h, d}, 1);
        $display("counter test done");
        wr(cc_timer_pkg::timer_control_idx, 8'h00);
        src.drive(1'b1);
        repeat (8) @(posedge core_clk);
        rdk(8'h80, 8'h00, "capture flag");
        capture(8'h00, 1'b0);
        rd(cc_timer_pkg::capture_low_idx, d);
        chk("capture", cs, {h, d}, 1);
        rdk(8'h80, 8'h00, "capture flag");
        capture(8'h02, 1'b1);
        src.drive(1'b0);
        src.drive(1'b1);
        repeat (40) @(posedge core_clk);
        rd(cc_timer_pkg::capture_low_idx, d);
        chk("capture", cs, {h, d}, 1);
        rdk(8'h80, 8'h80, "port bit", cc_timer_pkg::port_d_data_idx);
        $display("capture test done");
        t = m + 16'h0c + 16'($urandom_range(15));
        wr(cc_timer_pkg::compare_high_idx, t[15:8]);
        wr(cc_timer_pkg::compare_low_idx, t[7:0]);
        wr(cc_timer_pkg::timer_control_idx, 8'h41);
        n = 0;
        while (cp !== 1'b1) step;
        chk("match time", t + 16'h1, m, 1);
        chk("pin rises", 16'h1, 16'(src.rises));
        rdk(8'h40, 8'h40, "compare flag");
        chk("irq", 16'h1, {15'h0, irq});
        wr(cc_timer_pkg::timer_control_idx, 8'h40);
        wr(cc_timer_pkg::compare_high_idx, t[15:8] + 8'h1);
        repeat (1100) @(posedge core_clk);
        chk("pin held", 16'h1, {15'h0, cp});
        chk("pin rises", 16'h1, 16'(src.rises));
        wr(cc_timer_pkg::compare_low_idx, t[7:0]);
        rdk(8'h40, 8'h00, "compare flag");
        chk("irq", 16'h0, {15'h0, irq});
        $display("compare test done");
        wr(cc_timer_pkg::timer_control_idx, 8'h42);
        src.drive(1'b0);
        src.drive(1'b1);
        repeat (4) @(posedge core_clk);
        srst <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdk(8'hff, 8'h02, "control", cc_timer_pkg::timer_control_idx);
        rdk(8'h80, 8'h80, "capture flag");
        chk("compare pin", 16'h0, {15'h0, cp});
        $display("reset hold test done");
        end_sim;
    end
endmodule
`default_nettype wire
